// >>> bench/acr_host.sv
/*
 * host model: ahb-lite master doing single word transfers.
 * assumes hready is looped back from the slave's hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none
module acr_host (
    input  wire logic        clock,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // ****************
    // bus cycles
    // ****************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
                        output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
        // released data never shows the old word
        hwdata <= ~{16'h0, d};
    endtask : xfer
endmodule : acr_host
`default_nettype wire

// >>> bench/acr_top_sva.sv
/*
 * checker for the control register bank, bound to its top.
 * assumes one clock domain and a single bus master.
 */
`timescale 1ns/1ps
`default_nettype none
module acr_top_sva (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        internal_clock_en,
    input wire logic        filter_sync,
    input wire logic [2:0]  rate_reduction_code,
    input wire logic [5:0]  decimation_factor,
    input wire logic        full_power_down,
    input wire logic        reduced_power_select,
    input wire logic        amplifier_power_down,
    input wire logic        download_checksum_ok,
    input wire logic        download_busy
);
    // ****************
    // helpers
    // ****************
    logic wr_c1_ff;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_c1_ff <= 1'b0;
        end else if (hready) begin
            wr_c1_ff <= hsel && htrans[1] && hwrite && haddr == {22'h0, acr_pkg::ADDR_CTRL1};
        end
    end
    function automatic logic [5:0] dec_of(input logic [2:0] c);
        return (c > 3'h5) ? 6'h20 : 6'h01 << c;
    endfunction : dec_of
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_c1_wr;
        wr_c1_ff && hready && !download_busy;
    endsequence
    sequence s_dl_go;
        s_c1_wr ##0 (hwdata[15] && hwdata[8:5] != 4'h0);
    endsequence
    property p_rst_pwr;
        $rose(rst_b) |-> full_power_down && amplifier_power_down && !reduced_power_select;
    endproperty
    property p_pd_clk;
        full_power_down && $past(full_power_down) |-> !internal_clock_en;
    endproperty
    property p_dec;
        $past(rst_b) |-> decimation_factor == dec_of($past(rate_reduction_code));
    endproperty
    property p_sync;
        s_c1_wr ##0 (hwdata[9] && !full_power_down) |-> ##[1:4] filter_sync;
    endproperty
    property p_sync_pls;
        filter_sync |=> !filter_sync;
    endproperty
    property p_dl_go;
        s_dl_go |=> download_busy;
    endproperty
    property p_dl_clr;
        s_dl_go |=> !download_checksum_ok;
    endproperty
    property p_ok_rise;
        $rose(download_checksum_ok) |-> $past(download_busy) || $past(download_busy, 2);
    endproperty
    property p_hi;
        hrdata[31:16] == 16'h0000 && !hresp;
    endproperty
    a_rst_pwr: assert property (p_rst_pwr)
        else $error("power bits wrong after reset");
    a_pd_clk: assert property (p_pd_clk)
        else $error("clock enable during power down");
    a_dec: assert property (p_dec)
        else $error("decimation factor wrong");
    a_sync: assert property (p_sync)
        else $error("no sync pulse");
    a_sync_pls: assert property (p_sync_pls)
        else $error("sync not cleared");
    a_dl_go: assert property (p_dl_go)
        else $error("download not started");
    a_dl_clr: assert property (p_dl_clr)
        else $error("checksum flag kept at start");
    a_ok_rise: assert property (p_ok_rise)
        else $error("checksum flag outside download");
    a_hi: assert property (p_hi)
        else $error("upper read half or response wrong");
endmodule : acr_top_sva
bind acr_top acr_top_sva u_sva (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hrdata, .hresp, .internal_clock_en, .filter_sync, .rate_reduction_code,
    .decimation_factor, .full_power_down, .reduced_power_select, .amplifier_power_down,
    .download_checksum_ok, .download_busy);
`default_nettype wire

// >>> bench/adc_control_register_bank_tb.sv
/*
 * self-checking bench for the control register bank.
 * assumes the host model drives the bus and hready = hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_bank_tb;
    localparam logic [31:0] C1 = 32'h04;
    localparam logic [31:0] C2 = 32'h08;
    localparam logic [31:0] RES = 32'h00;
    localparam logic [31:0] STA = 32'h18;
    logic clock, rst_b, hsel, hwrite, hreadyout, hresp, ovr, fck;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, rate;
    logic [15:0] conv, gain, offs, thr;
    logic [5:0] coef_index, dec;
    logic [26:0] coef_value;
    logic icken, sync, f3, f1, pd, lp, amp, ok, uf, busy;
    int err_total;
    int samples_checked;
    logic [15:0] wd [12] = '{16'h032B, 16'h9688, 16'h01BF, 16'h183C, 16'h0015, 16'h6626,
                             16'h04A8, 16'h1E6A, 16'h045F, 16'h2A96, 16'h002C, 16'h49C2};
    logic [15:0] sel [4] = '{16'hCCCC, 16'hA000, 16'h0011, 16'h0105};
    // ****************
    // structure
    // ****************
    acr_host u_host (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    acr_top dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conversion_data(conv),
        .gain_value(gain), .offset_value(offs), .threshold_value(thr),
        .overrange_flag(ovr), .filter_check_ok(fck), .coef_index(coef_index),
        .coef_value(coef_value), .internal_clock_en(icken), .filter_sync(sync),
        .third_filter_enable(f3), .first_filter_enable(f1), .rate_reduction_code(rate),
        .decimation_factor(dec), .full_power_down(pd), .reduced_power_select(lp),
        .amplifier_power_down(amp), .download_checksum_ok(ok), .user_filter_active(uf),
        .download_busy(busy));
    always #2.5 clock = ~clock;
    // ****************
    // tasks
    // ****************
    task automatic print_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] v;
        u_host.xfer(1'b1, a, d, v);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
        logic [31:0] v;
        u_host.xfer(1'b0, a, 16'h0, v);
        chk(n, e, v);
    endtask : rd
    task automatic clk_cnt(input logic [31:0] e);
        logic [31:0] c;
        c = 0;
        repeat (3) @(posedge clock);
        repeat (20) begin
            @(posedge clock);
            #1;
            c = c + (icken === 1'b1);
        end
        chk("clock enables", e, c);
    endtask : clk_cnt
    task automatic dl(input logic [15:0] bad);
        logic [15:0] s;
        s = 16'h0;
        wr(C1, 16'h803D);
        #1;
        chk("busy", 1, busy);
        for (int i = 0; i < 12; i++) begin
            wr(C1, wd[i]);
            s = s + wd[i][15:8] + wd[i][7:0];
        end
        wr(C1, s + bad);
        #1;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
            @(posedge clock);
            #1;
        end
        chk("checksum ok", bad == 16'h0, ok);
    endtask : dl
    task automatic coef(input logic [5:0] i, input logic [26:0] e);
        @(posedge clock);
        coef_index <= i;
        repeat (2) @(posedge clock);
        #1;
        chk("coefficient", e, coef_value);
    endtask : coef
    // ****************
    // tests
    // ****************
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        coef_index = 6'h0;
        conv = 16'h1234;
        gain = 16'hA000;
        offs = 16'h0011;
        thr = 16'hCCCC;
        ovr = 1'b1;
        fck = 1'b0;
        err_total = 0;
        samples_checked = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        rd(C1, 32'h001A, "ctrl1 reset");
        rd(C2, 32'h009B, "ctrl2 reset");
        chk("power bits", 3'b101, {pd, lp, amp});
        wr(C2, 16'h0002);
        clk_cnt(10);
        chk("power bits", 3'b000, {pd, lp, amp});
        wr(C2, 16'h0026);
        clk_cnt(20);
        chk("power bits", 3'b010, {pd, lp, amp});
        wr(C2, 16'h000B);
        clk_cnt(0);
        chk("power bits", 3'b101, {pd, lp, amp});
        wr(C2, 16'h0022);
        wr(32'h0C, 16'hFFFF);
        rd(32'h0C, 32'h0, "unmapped");
        rd(C2, 32'h0022, "ctrl2");
        for (int k = 0; k < 6; k++) begin
            wr(C1, {11'h0, k[0], ~k[0], k[2:0]});
            repeat (2) @(posedge clock);
            #1;
            chk("ctrl1 fields", {k[0], ~k[0], k[2:0], 6'h01 << k}, {f3, f1, rate, dec});
        end
        for (int s = 0; s < 4; s++) begin
            wr(C1, (16'h4000 >> s) | 16'h001D);
            rd(RES, sel[s], "selected word");
            rd(C1, 32'h001D, "select cleared");
            rd(RES, 32'h1234, "conversion word");
        end
        rd(STA, 32'h0105, "status");
        wr(C1, 16'h021D);
        for (int i = 0; i < 50 && sync !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("sync pulse", 1, sync);
        rd(C1, 32'h001D, "sync cleared");
        dl(16'h0);
        chk("user filter", 1, uf);
        chk("response", 0, hresp);
        coef(6'h00, {wd[0][10:0], wd[1]});
        coef(6'h05, {wd[10][10:0], wd[11]});
        coef(6'h06, 27'h0);
        rd(C1, 32'h003D, "download cleared");
        rd(STA, 32'h01A5, "status after download");
        dl(16'h0001);
        print_verdict();
    end
endmodule : adc_control_register_bank_tb
`default_nettype wire

// >>> src/acr_pkg.sv
/*
 * constants for the converter control register bank: word indices, byte
 * addresses, field positions, reset values and download sizes.
 * assumes a 32-bit ahb-lite bus with one aligned word per register.
 */
// How it works
// - address then one 16-bit data word
// - download bit routes later writes to coefficients
// - length code sets coefficient count
// - threshold select: next read gives threshold
// - gain select: next read gives gain
// - bias select: next read gives offset
// - status select: next read gives status
// - bits fifteen to nine clear themselves
// - alignment bit starts synchronisation routine
// - third filter enable, else bypassed
// - first filter enable, else raw data
// - rate code sets second filter decimation
// - second register resets to 0x009B
// - clock halving select sets internal clock
// - full power down stops converter
// - reduced power select enters low power
// - amplifier power down bit
// - checksum ok only when sums agree

package acr_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  IDX_RESULT   = 8'h00;
    localparam logic [7:0]  IDX_CTRL1    = 8'h01;
    localparam logic [7:0]  IDX_CTRL2    = 8'h02;
    localparam logic [7:0]  IDX_STATUS   = 8'h06;
    localparam logic [9:0]  ADDR_RESULT  = {IDX_RESULT, 2'h0};
    localparam logic [9:0]  ADDR_CTRL1   = {IDX_CTRL1, 2'h0};
    localparam logic [9:0]  ADDR_CTRL2   = {IDX_CTRL2, 2'h0};
    localparam logic [9:0]  ADDR_STATUS  = {IDX_STATUS, 2'h0};

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] CTRL1_RST    = 16'h001A;
    localparam logic [15:0] CTRL2_RST    = 16'h009B;

    // ****************************************
    // first control register fields
    // ****************************************
    localparam int          C1_DL        = 15;
    localparam int          C1_RD_THR    = 14;
    localparam int          C1_RD_GAIN   = 13;
    localparam int          C1_RD_BIAS   = 12;
    localparam int          C1_RD_STAT   = 11;
    localparam int          C1_ZERO      = 10;
    localparam int          C1_SYNC      = 9;
    localparam int          C1_FILTER_LENGTH_CODE_LO   = 5;
    localparam int          C1_F3        = 4;
    localparam int          C1_F1        = 3;
    localparam int          C1_RATE_LO   = 0;
    localparam logic [15:0] C1_SELF_MASK = 16'hFE00;

    // ****************************************
    // second control register fields
    // ****************************************
    localparam int          C2_HALF      = 5;
    localparam int          C2_PD        = 3;
    localparam int          C2_REDUCED_POWER_SELECT      = 2;
    localparam int          C2_AMP_PD    = 0;

    // ****************************************
    // coefficient store
    // ****************************************
    localparam int          COEF_N       = 48;
    localparam int          COEF_W       = 27;
    localparam logic [6:0]  COEF_PER_STEP = 7'h03;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_FILL = 3'b100
    } acr_state_t;

endpackage : acr_pkg

// >>> src/acr_top.sv
/*
 * control register bank of a sigma-delta converter back end, with the
 * user coefficient download engine and the read-select path.
 * assumes a single ahb-lite master doing single word transfers; gain,
 * offset, threshold and conversion data come in from the datapath.
 */
`timescale 1ns/1ps
`default_nettype none

module acr_top #(
    // arbitrary identification values
    parameter logic [1:0] PART_CODE = 2'h0,
    parameter logic [2:0] DIE_CODE  = 3'h0
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] conversion_data,
    input  wire logic [15:0] gain_value,
    input  wire logic [15:0] offset_value,
    input  wire logic [15:0] threshold_value,
    input  wire logic        overrange_flag,
    input  wire logic        filter_check_ok,
    input  wire logic [5:0]  coef_index,
    output logic      [26:0] coef_value,
    output logic             internal_clock_en,
    output logic             filter_sync,
    output logic             third_filter_enable,
    output logic             first_filter_enable,
    output logic      [2:0]  rate_reduction_code,
    output logic      [5:0]  decimation_factor,
    output logic             full_power_down,
    output logic             reduced_power_select,
    output logic             amplifier_power_down,
    output logic             download_checksum_ok,
    output logic             user_filter_active,
    output logic             download_busy
);

    // ****************************************
    // declarations
    // ****************************************
    logic [15:0]         ctrl1_ff;
    logic [15:0]         nxt_ctrl1;
    logic [15:0]         ctrl2_ff;
    logic                wr_pend_ff;
    logic [9:0]          wr_addr_ff;
    logic                wr_en;
    logic [15:0]         wdata;
    logic                rd_take;
    logic [9:0]          addr_in;
    logic [31:0]         hrdata_ff;
    logic                hreadyout_ff;
    logic                hresp_ff;
    logic [15:0]         status_word;
    logic [15:0]         rd_word;
    logic                div_ff;
    logic                internal_clock_en_ff;
    logic                sync_pend_ff;
    logic                sync_ff;
    acr_pkg::acr_state_t state_ff;
    logic [6:0]          wcnt_ff;
    logic [6:0]          nwords;
    logic [5:0]          fill_ff;
    logic [15:0]         sum_ff;
    logic [10:0]         hi_ff;
    logic [acr_pkg::COEF_W-1:0] coef_mem [acr_pkg::COEF_N];
    logic [26:0]         coef_ff;
    logic                download_checksum_ok_ff;
    logic                ufilt_ff;
    logic                load_wr;
    logic                dl_start;
    logic                dl_done;
    logic [5:0]          dec_ff;

    // ****************************************
    // ahb-lite slave
    // ****************************************
    assign addr_in = haddr[9:0];
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_en   = wr_pend_ff;
    assign wdata   = hwdata[15:0];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 10'h000;
        end else if (hready) begin
            wr_pend_ff <= hsel && htrans[1] && hwrite;
            wr_addr_ff <= addr_in;
        end
    end

    // zero wait states, always okay: registers are plain flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout_ff <= 1'b0;
            hresp_ff     <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    always_comb begin
        status_word = {PART_CODE, DIE_CODE, 1'b0, ctrl2_ff[acr_pkg::C2_REDUCED_POWER_SELECT],
                       overrange_flag, download_checksum_ok_ff, filter_check_ok, ufilt_ff,
                       ~ctrl1_ff[acr_pkg::C1_F3], ~ctrl1_ff[acr_pkg::C1_F1],
                       ctrl1_ff[acr_pkg::C1_RATE_LO +: 3]};
    end

    // pending select decides what the result word returns
    always_comb begin
        rd_word = conversion_data;
        if (ctrl1_ff[acr_pkg::C1_RD_THR]) begin
            rd_word = threshold_value;
        end else if (ctrl1_ff[acr_pkg::C1_RD_GAIN]) begin
            rd_word = gain_value;
        end else if (ctrl1_ff[acr_pkg::C1_RD_BIAS]) begin
            rd_word = offset_value;
        end else if (ctrl1_ff[acr_pkg::C1_RD_STAT]) begin
            rd_word = status_word;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_take) begin
            unique case (addr_in)
                acr_pkg::ADDR_RESULT: hrdata_ff <= {16'h0000, rd_word};
                acr_pkg::ADDR_CTRL1:  hrdata_ff <= {16'h0000, ctrl1_ff};
                acr_pkg::ADDR_CTRL2:  hrdata_ff <= {16'h0000, ctrl2_ff};
                acr_pkg::ADDR_STATUS: hrdata_ff <= {16'h0000, status_word};
                default:              hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // download engine
    // ****************************************
    // length code to word count
    always_comb begin
        nwords = 7'(({3'h0, ctrl1_ff[acr_pkg::C1_FILTER_LENGTH_CODE_LO +: 4]} | 7'h01) + 7'h01);
        nwords = 7'(nwords * acr_pkg::COEF_PER_STEP * 7'h02);
    end

    // during load every write is coefficient data, except the last, which is the checksum
    assign load_wr  = wr_en && (state_ff == acr_pkg::ST_LOAD);
    assign dl_start = wr_en && (state_ff == acr_pkg::ST_IDLE)
                      && (wr_addr_ff == acr_pkg::ADDR_CTRL1)
                      && wdata[acr_pkg::C1_DL] && (wdata[acr_pkg::C1_FILTER_LENGTH_CODE_LO +: 4] != 4'h0);
    assign dl_done  = (state_ff == acr_pkg::ST_FILL) && internal_clock_en_ff
                      && (fill_ff == 6'(acr_pkg::COEF_N - 1));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= acr_pkg::ST_IDLE;
            wcnt_ff  <= 7'h00;
            fill_ff  <= 6'h00;
            sum_ff   <= 16'h0000;
            hi_ff    <= 11'h000;
        end else begin
            unique case (state_ff)
                acr_pkg::ST_IDLE: begin
                    if (dl_start) begin
                        state_ff <= acr_pkg::ST_LOAD;
                        wcnt_ff  <= 7'h00;
                        sum_ff   <= 16'h0000;
                    end
                end
                acr_pkg::ST_LOAD: begin
                    if (load_wr) begin
                        wcnt_ff <= wcnt_ff + 7'h01;
                        if (wcnt_ff == nwords) begin
                            state_ff <= acr_pkg::ST_FILL;
                            fill_ff  <= 6'(wcnt_ff >> 1);
                        end else begin
                            sum_ff <= sum_ff + {8'h00, wdata[15:8]} + {8'h00, wdata[7:0]};
                            if (!wcnt_ff[0]) begin
                                hi_ff <= wdata[10:0];
                            end
                        end
                    end
                end
                acr_pkg::ST_FILL: begin
                    // unused taps zeroed at the internal clock rate
                    if (internal_clock_en_ff && !dl_done) begin
                        fill_ff <= fill_ff + 6'h01;
                    end
                    if (dl_done) begin
                        state_ff <= acr_pkg::ST_IDLE;
                    end
                end
                default: state_ff <= acr_pkg::ST_IDLE;
            endcase
        end
    end

    // coefficient store, one word pair per tap
    always_ff @(posedge clock) begin
        if (load_wr && wcnt_ff[0] && (wcnt_ff < nwords)) begin
            coef_mem[wcnt_ff[6:1]] <= {hi_ff, wdata};
        end else if ((state_ff == acr_pkg::ST_FILL) && internal_clock_en_ff) begin
            coef_mem[fill_ff] <= '0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            coef_ff <= 27'h0000000;
        end else if (coef_index < 6'(acr_pkg::COEF_N)) begin
            coef_ff <= coef_mem[coef_index];
        end else begin
            coef_ff <= 27'h0000000;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            download_checksum_ok_ff <= 1'b0;
            ufilt_ff <= 1'b0;
        end else if (dl_start) begin
            download_checksum_ok_ff <= 1'b0;
            ufilt_ff <= 1'b0;
        end else if (load_wr && (wcnt_ff == nwords)) begin
            download_checksum_ok_ff <= (wdata == sum_ff);
            ufilt_ff <= (wdata == sum_ff);
        end
    end

    // ****************************************
    // first control register
    // ****************************************
    always_comb begin
        nxt_ctrl1 = ctrl1_ff;
        nxt_ctrl1[acr_pkg::C1_ZERO] = 1'b0;
        if (rd_take && (addr_in == acr_pkg::ADDR_RESULT)) begin
            nxt_ctrl1[acr_pkg::C1_RD_STAT +: 4] = 4'h0;
        end
        if (sync_ff) begin
            nxt_ctrl1[acr_pkg::C1_SYNC] = 1'b0;
        end
        if (dl_done || (state_ff == acr_pkg::ST_IDLE)) begin
            nxt_ctrl1[acr_pkg::C1_DL] = 1'b0;
        end
        // a fresh write wins over any clear in the same cycle, except bit 15, which stays set only if the write starts a download
        if (wr_en && (state_ff == acr_pkg::ST_IDLE) && (wr_addr_ff == acr_pkg::ADDR_CTRL1)) begin
            nxt_ctrl1 = wdata;
            if (!dl_start) begin
                nxt_ctrl1[acr_pkg::C1_DL] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl1_ff <= acr_pkg::CTRL1_RST;
        end else begin
            ctrl1_ff <= nxt_ctrl1;
        end
    end

    // ****************************************
    // second control register
    // ****************************************
    // reset value
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl2_ff <= acr_pkg::CTRL2_RST;
        end else if (wr_en && (state_ff == acr_pkg::ST_IDLE)
                     && (wr_addr_ff == acr_pkg::ADDR_CTRL2)) begin
            ctrl2_ff <= wdata;
        end
    end

    // ****************************************
    // internal clock and synchronisation
    // ****************************************
    // halve unless select set
    // power down stops the internal clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_ff     <= 1'b0;
            internal_clock_en_ff <= 1'b0;
        end else begin
            div_ff     <= ~div_ff;
            internal_clock_en_ff <= !ctrl2_ff[acr_pkg::C2_PD] && (ctrl2_ff[acr_pkg::C2_HALF] || div_ff);
        end
    end

    // sync pulse on internal clock edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_pend_ff <= 1'b0;
            sync_ff      <= 1'b0;
        end else begin
            sync_ff <= sync_pend_ff && internal_clock_en_ff;
            if (wr_en && (state_ff == acr_pkg::ST_IDLE) && (wr_addr_ff == acr_pkg::ADDR_CTRL1)
                && wdata[acr_pkg::C1_SYNC]) begin
                sync_pend_ff <= 1'b1;
            end else if (internal_clock_en_ff) begin
                sync_pend_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dec_ff <= 6'h01;
        end else if (ctrl1_ff[2:0] > 3'h5) begin
            dec_ff <= 6'h20;
        end else begin
            dec_ff <= 6'(7'h01 << ctrl1_ff[2:0]);
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hrdata               = hrdata_ff;
    assign hreadyout            = hreadyout_ff;
    assign hresp                = hresp_ff;
    assign coef_value           = coef_ff;
    assign internal_clock_en    = internal_clock_en_ff;
    assign filter_sync          = sync_ff;
    assign third_filter_enable  = ctrl1_ff[acr_pkg::C1_F3];
    assign first_filter_enable  = ctrl1_ff[acr_pkg::C1_F1];
    assign rate_reduction_code  = ctrl1_ff[acr_pkg::C1_RATE_LO +: 3];
    assign decimation_factor    = dec_ff;
    assign full_power_down      = ctrl2_ff[acr_pkg::C2_PD];
    assign reduced_power_select = ctrl2_ff[acr_pkg::C2_REDUCED_POWER_SELECT];
    assign amplifier_power_down = ctrl2_ff[acr_pkg::C2_AMP_PD];
    assign download_checksum_ok = download_checksum_ok_ff;
    assign user_filter_active   = ufilt_ff;
    assign download_busy        = state_ff != acr_pkg::ST_IDLE;

endmodule : acr_top

`default_nettype wire
